// ---- design/ccsr_pkg.sv ----
// Shared constants, enumerations and carrier structs for the processor control-state block.
// Assumes one core clock and instruction logic inside the core as the only client.
package ccsr_pkg;

    // ************************************************************
    // Status word layout and reset values
    // ************************************************************
    localparam int          PRIV_BIT      = 30;
    localparam int          BANK_BIT      = 29;
    localparam int          BLOCK_BIT     = 28;
    localparam int          DIVM_BIT      = 9;
    localparam int          DIVQ_BIT      = 8;
    localparam int          IMASK_HI      = 7;
    localparam int          IMASK_LO      = 4;
    localparam int          SAT_BIT       = 1;
    localparam int          FLAG_BIT      = 0;
    localparam logic [31:0] SR_VALID_MASK = 32'h700003F3;
    localparam logic [31:0] SR_USER_MASK  = 32'h00000303;
    localparam logic [31:0] SR_RESET      = 32'h700000F0;
    localparam logic [3:0]  IMASK_RESET   = 4'hF;
    localparam logic [31:0] BOOT_ADDR     = 32'hA0000000;
    localparam logic [31:0] VBR_RESET     = 32'h00000000;
    localparam logic [31:0] ZERO_WORD     = 32'h00000000;
    localparam logic [31:0] INSTR_BYTES   = 32'h00000002;

    // ************************************************************
    // Enumerations
    // ************************************************************
    typedef enum logic [2:0] {
        CCSR_SEL_STATUS = 3'b000,
        CCSR_SEL_GBASE  = 3'b001,
        CCSR_SEL_VBASE  = 3'b010,
        CCSR_SEL_SSTAT  = 3'b011,
        CCSR_SEL_SRET   = 3'b100
    } ccsr_sel_e;

    typedef enum logic [1:0] {
        CCSR_SIZE_BYTE = 2'b00,
        CCSR_SIZE_WORD = 2'b01,
        CCSR_SIZE_LONG = 2'b10
    } ccsr_size_e;

    typedef enum logic [2:0] {
        CCSR_LIT_MOV = 3'b000,
        CCSR_LIT_ADD = 3'b001,
        CCSR_LIT_CMP = 3'b010,
        CCSR_LIT_TST = 3'b011,
        CCSR_LIT_AND = 3'b100,
        CCSR_LIT_OR  = 3'b101,
        CCSR_LIT_XOR = 3'b110
    } ccsr_lit_e;

    typedef enum logic [2:0] {
        CCSR_FS_PLAIN   = 3'b000,
        CCSR_FS_COMPARE = 3'b001,
        CCSR_FS_TEST    = 3'b010,
        CCSR_FS_DECTEST = 3'b011,
        CCSR_FS_ARITH   = 3'b100,
        CCSR_FS_SHIFT   = 3'b101,
        CCSR_FS_ROTATE  = 3'b110
    } ccsr_fsrc_e;

    typedef enum logic [1:0] {
        CCSR_BR_NONE    = 2'b00,
        CCSR_BR_DELAYED = 2'b01,
        CCSR_BR_PLAIN   = 2'b10
    } ccsr_br_e;

    // ************************************************************
    // Carrier structs
    // ************************************************************
    typedef struct packed {
        logic        valid;
        logic        write;
        ccsr_sel_e   sel;
        logic [31:0] wdata;
    } ccsr_ctrl_s;

    typedef struct packed {
        logic        valid;
        ccsr_size_e  size;
        logic [31:0] addr;
        logic [31:0] rdata;
    } ccsr_mem_s;

    typedef struct packed {
        logic        valid;
        ccsr_lit_e   op;
        logic [7:0]  imm;
    } ccsr_lit_s;

    typedef struct packed {
        logic        valid;
        ccsr_fsrc_e  src;
        logic        value;
    } ccsr_flag_s;

    typedef struct packed {
        ccsr_br_e    kind;
        logic        taken;
        logic [31:0] target;
    } ccsr_branch_s;

endpackage

// ---- design/ccsr_control_state.sv ----
// Control and status state of the core: status word, saved state, base registers,
// operand sizing, alignment, byte order, literal extension and delayed-branch sequencing.
// Assumes requests come from instruction logic on the same clock, one instruction per step.
`timescale 1ns/1ns

module ccsr_control_state #(
    parameter logic [31:0] BOOT_ADDR_P = ccsr_pkg::BOOT_ADDR
) (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 powerOnReset,
    input  wire logic                 endianSelectPin,
    // Instruction sequencing.
    input  wire logic                 instrStep,
    input  wire ccsr_pkg::ccsr_branch_s branchReq,
    input  wire logic                 excReq,
    input  wire logic [31:0]          excOffset,
    input  wire logic                 returnReq,
    // Control-register moves and flag updates.
    input  wire ccsr_pkg::ccsr_ctrl_s ctrlReq,
    input  wire ccsr_pkg::ccsr_flag_s flagReq,
    // Memory operands and literals.
    input  wire ccsr_pkg::ccsr_mem_s  memReq,
    input  wire ccsr_pkg::ccsr_lit_s  litReq,
    // Architectural state.
    output logic [31:0]               pc,
    output logic [31:0]               statusWord,
    output logic [31:0]               savedStatus,
    output logic [31:0]               savedReturnAddress,
    output logic [31:0]               globalBase,
    output logic [31:0]               vectorBase,
    output logic                      littleEndian,
    // Answers to the instruction logic.
    output logic [31:0]               ctrlReadData,
    output logic                      ctrlFault,
    output logic                      excTaken,
    output logic                      addrError,
    output logic [31:0]               loadValue,
    output logic [31:0]               literalValue
);

    // ************************************************************
    // Sequencer state
    // ************************************************************
    typedef enum logic {
        CCSR_ST_RUN  = 1'b0,
        CCSR_ST_SLOT = 1'b1
    } ccsr_state_e;

    ccsr_state_e state_reg;
    ccsr_state_e state_next;
    logic [31:0] pc_reg;
    logic [31:0] pc_next;
    logic [31:0] slotTarget_reg;
    logic [31:0] slotTarget_next;
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [31:0] savedStatus_reg;
    logic [31:0] savedRet_reg;
    logic [31:0] globalBase_reg;
    logic [31:0] vectorBase_reg;
    logic        endian_reg;
    logic [31:0] ctrlRdata_reg;
    logic        ctrlFault_reg;
    logic        excTaken_reg;
    logic        addrError_reg;
    logic [31:0] loadValue_reg;
    logic [31:0] literal_reg;

    // ************************************************************
    // Decode of requests
    // ************************************************************
    // The block bit holds off exceptions, so a request while it is set is simply not taken.
    wire        isPriv      = status_reg[ccsr_pkg::PRIV_BIT];
    wire        excAccept   = excReq && !status_reg[ccsr_pkg::BLOCK_BIT];
    wire        retAccept   = returnReq && !excAccept;
    wire        ctrlWr      = ctrlReq.valid && ctrlReq.write;
    wire        selGbase    = ctrlReq.sel == ccsr_pkg::CCSR_SEL_GBASE;
    wire        selStatus   = ctrlReq.sel == ccsr_pkg::CCSR_SEL_STATUS;
    wire        userSrWrite = ctrlWr && selStatus && !isPriv;
    wire        ctrlAllowed = isPriv || selGbase || (selStatus && ctrlReq.write);
    wire        ctrlGo      = ctrlReq.valid && ctrlAllowed;
    wire        wrGo        = ctrlGo && ctrlReq.write;

    // Flag writers are limited to the instruction classes that define the flag.
    wire        flagAllowed = flagReq.src != ccsr_pkg::CCSR_FS_PLAIN;
    wire        flagGo      = flagReq.valid && flagAllowed;

    // User status writes only reach divide-step, saturation and flag bits.
    wire [31:0] srWrMask    = isPriv ? ccsr_pkg::SR_VALID_MASK : ccsr_pkg::SR_USER_MASK;
    wire [31:0] srWrValue   = ctrlReq.wdata & ccsr_pkg::SR_VALID_MASK;
    wire [31:0] srMerged    = (status_reg & ~srWrMask) | (srWrValue & srWrMask);

    // Control read selection.
    wire [31:0] ctrlMux =
        (ctrlReq.sel == ccsr_pkg::CCSR_SEL_STATUS) ? status_reg :
        (ctrlReq.sel == ccsr_pkg::CCSR_SEL_GBASE)  ? globalBase_reg :
        (ctrlReq.sel == ccsr_pkg::CCSR_SEL_VBASE)  ? vectorBase_reg :
        (ctrlReq.sel == ccsr_pkg::CCSR_SEL_SSTAT)  ? savedStatus_reg :
        (ctrlReq.sel == ccsr_pkg::CCSR_SEL_SRET)   ? savedRet_reg :
                                                     ccsr_pkg::ZERO_WORD;

    // ************************************************************
    // Memory operands and literals
    // ************************************************************
    // Alignment depends only on size and low address bits; bytes never fault.
    wire isWord    = memReq.size == ccsr_pkg::CCSR_SIZE_WORD;
    wire isLong    = memReq.size == ccsr_pkg::CCSR_SIZE_LONG;
    wire misalign  = (isWord && memReq.addr[0]) || (isLong && |memReq.addr[1:0]);

    // Loaded data arrives right-justified; lane steering by byte order is done upstream.
    wire [31:0] byteExt = {{24{memReq.rdata[7]}}, memReq.rdata[7:0]};
    wire [31:0] wordExt = {{16{memReq.rdata[15]}}, memReq.rdata[15:0]};
    wire [31:0] loadExt = (memReq.size == ccsr_pkg::CCSR_SIZE_BYTE) ? byteExt :
                          isWord ? wordExt : memReq.rdata;

    wire litSigned = (litReq.op == ccsr_pkg::CCSR_LIT_MOV) ||
                     (litReq.op == ccsr_pkg::CCSR_LIT_ADD) ||
                     (litReq.op == ccsr_pkg::CCSR_LIT_CMP);
    wire [31:0] litExt = litSigned ? {{24{litReq.imm[7]}}, litReq.imm}
                                   : {24'h000000, litReq.imm};

    // ************************************************************
    // Program counter sequencing
    // ************************************************************
    // Exception beats return, and both beat an ordinary step in the same cycle.
    wire [31:0] pcInc = pc_reg + ccsr_pkg::INSTR_BYTES;
    wire        brTaken = branchReq.taken && branchReq.kind != ccsr_pkg::CCSR_BR_NONE;

    always_comb begin
        pc_next         = pc_reg;
        state_next      = state_reg;
        slotTarget_next = slotTarget_reg;
        if (excAccept) begin
            pc_next    = vectorBase_reg + excOffset;
            state_next = CCSR_ST_RUN;
        end else if (retAccept) begin
            pc_next    = savedRet_reg;
            state_next = CCSR_ST_RUN;
        end else if (instrStep) begin
            case (state_reg)
                CCSR_ST_SLOT: begin
                    pc_next    = slotTarget_reg;
                    state_next = CCSR_ST_RUN;
                end
                CCSR_ST_RUN: begin
                    if (brTaken && branchReq.kind == ccsr_pkg::CCSR_BR_DELAYED) begin
                        slotTarget_next = branchReq.target;
                        pc_next         = pcInc;
                        state_next      = CCSR_ST_SLOT;
                    end else if (brTaken) begin
                        pc_next = branchReq.target;
                    end else begin
                        pc_next = pcInc;
                    end
                end
                default: begin
                    state_next = CCSR_ST_RUN;
                end
            endcase
        end
    end

    // ************************************************************
    // Status word update
    // ************************************************************
    // Exception entry raises privilege, bank and block but leaves the mask level alone.
    always_comb begin
        status_next = status_reg;
        if (excAccept) begin
            status_next[ccsr_pkg::PRIV_BIT]  = 1'b1;
            status_next[ccsr_pkg::BANK_BIT]  = 1'b1;
            status_next[ccsr_pkg::BLOCK_BIT] = 1'b1;
        end else if (retAccept) begin
            status_next = savedStatus_reg & ccsr_pkg::SR_VALID_MASK;
        end else begin
            if ((wrGo && selStatus) || userSrWrite) begin
                status_next = srMerged;
            end
            if (flagGo) begin
                status_next[ccsr_pkg::FLAG_BIT] = flagReq.value;
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Status and program counter take their documented reset values.
    always_ff @(posedge clk) begin
        if (reset) begin
            pc_reg         <= BOOT_ADDR_P;
            status_reg     <= ccsr_pkg::SR_RESET;
            state_reg      <= CCSR_ST_RUN;
            slotTarget_reg <= ccsr_pkg::ZERO_WORD;
            vectorBase_reg <= ccsr_pkg::VBR_RESET;
        end else begin
            pc_reg         <= pc_next;
            status_reg     <= status_next;
            state_reg      <= state_next;
            slotTarget_reg <= slotTarget_next;
            if (wrGo && ctrlReq.sel == ccsr_pkg::CCSR_SEL_VBASE) begin
                vectorBase_reg <= ctrlReq.wdata;
            end
        end
    end

    // Saved state is captured at exception entry; otherwise privileged moves may load it.
    always_ff @(posedge clk) begin
        if (reset) begin
            savedStatus_reg <= ccsr_pkg::ZERO_WORD;
            savedRet_reg    <= ccsr_pkg::ZERO_WORD;
        end else if (excAccept) begin
            savedStatus_reg <= status_reg;
            savedRet_reg    <= pc_reg;
        end else if (wrGo) begin
            if (ctrlReq.sel == ccsr_pkg::CCSR_SEL_SSTAT) savedStatus_reg <= ctrlReq.wdata;
            if (ctrlReq.sel == ccsr_pkg::CCSR_SEL_SRET) savedRet_reg <= ctrlReq.wdata;
        end
    end

    // Global base is reachable from user mode as well.
    always_ff @(posedge clk) begin
        if (reset) begin
            globalBase_reg <= ccsr_pkg::ZERO_WORD;
        end else if (wrGo && selGbase) begin
            globalBase_reg <= ctrlReq.wdata;
        end
    end

    // Byte order is latched only during a power-on reset, so a manual reset keeps it.
    always_ff @(posedge clk) begin
        if (reset && powerOnReset) begin
            endian_reg <= endianSelectPin;
        end
    end

    // Registered answers to the instruction logic, one cycle after each request.
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlRdata_reg <= ccsr_pkg::ZERO_WORD;
            ctrlFault_reg <= 1'b0;
            excTaken_reg  <= 1'b0;
            addrError_reg <= 1'b0;
            loadValue_reg <= ccsr_pkg::ZERO_WORD;
            literal_reg   <= ccsr_pkg::ZERO_WORD;
        end else begin
            ctrlRdata_reg <= (ctrlGo && !ctrlReq.write) ? ctrlMux : ctrlRdata_reg;
            ctrlFault_reg <= ctrlReq.valid && !ctrlAllowed;
            excTaken_reg  <= excAccept;
            addrError_reg <= memReq.valid && misalign;
            loadValue_reg <= memReq.valid ? loadExt : loadValue_reg;
            literal_reg   <= litReq.valid ? litExt : literal_reg;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign pc                 = pc_reg;
    assign statusWord         = status_reg;
    assign savedStatus        = savedStatus_reg;
    assign savedReturnAddress = savedRet_reg;
    assign globalBase         = globalBase_reg;
    assign vectorBase         = vectorBase_reg;
    assign littleEndian       = endian_reg;
    assign ctrlReadData       = ctrlRdata_reg;
    assign ctrlFault          = ctrlFault_reg;
    assign excTaken           = excTaken_reg;
    assign addrError          = addrError_reg;
    assign loadValue          = loadValue_reg;
    assign literalValue       = literal_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_exc_saves_pc: assert property (excAccept |=> savedRet_reg == $past(pc_reg))
        else $error("Saved return address missed the program counter.");
    a_ret_loads_pc: assert property (retAccept |=> pc_reg == $past(savedRet_reg))
        else $error("Return did not reload the program counter.");
    a_exc_saves_sr: assert property (excAccept |=> savedStatus_reg == $past(status_reg))
        else $error("Saved status missed the status word.");
    a_exc_mode_bits: assert property (excAccept |=> status_reg[30:28] == 3'b111
        && status_reg[7:4] == $past(status_reg[7:4]))
        else $error("Exception entry set wrong mode or mask bits.");
    a_reserved_zero: assert property ((status_reg & ~ccsr_pkg::SR_VALID_MASK) == 32'h0)
        else $error("Reserved status bit is not zero.");
    a_user_ctrl_fault: assert property (ctrlWr && !isPriv && !selGbase && !selStatus
        |=> ctrlFault_reg && $stable(vectorBase_reg))
        else $error("User control move was not refused.");
    a_user_sr_guard: assert property (userSrWrite && !excAccept && !retAccept
        |=> status_reg[31:10] == $past(status_reg[31:10]))
        else $error("User write changed a privileged status bit.");
    a_align_error: assert property (memReq.valid && isLong && memReq.addr[1:0] == 2'b10
        |=> addrError_reg)
        else $error("Misaligned longword did not flag an address error.");
    a_odd_word_error: assert property (memReq.valid && isWord && memReq.addr[0]
        |=> addrError_reg)
        else $error("Odd word access did not flag an address error.");
    a_exc_vector: assert property (excAccept
        |=> pc_reg == $past(vectorBase_reg) + $past(excOffset) && excTaken_reg)
        else $error("Exception entry did not jump into the vector area.");
    a_arith_signext: assert property (litReq.valid && litReq.op == ccsr_pkg::CCSR_LIT_MOV
        |=> literal_reg[31:8] == {24{literal_reg[7]}})
        else $error("Move literal was not sign-extended.");
    a_byte_signext: assert property (memReq.valid && memReq.size == ccsr_pkg::CCSR_SIZE_BYTE
        |=> loadValue_reg[31:8] == {24{loadValue_reg[7]}})
        else $error("Byte load was not sign-extended.");
    a_logic_zeroext: assert property (litReq.valid && litReq.op == ccsr_pkg::CCSR_LIT_TST
        |=> literal_reg[31:8] == 24'h000000)
        else $error("Logic literal was not zero-extended.");
    a_plain_flag: assert property (flagReq.valid && !flagAllowed && !ctrlWr && !retAccept
        |=> $stable(status_reg[ccsr_pkg::FLAG_BIT]))
        else $error("Plain instruction changed the condition flag.");
    a_delay_slot: assert property (state_reg == CCSR_ST_RUN && instrStep && brTaken
        && branchReq.kind == ccsr_pkg::CCSR_BR_DELAYED && !excAccept && !retAccept
        |=> pc_reg == $past(pcInc) && state_reg == CCSR_ST_SLOT)
        else $error("Delayed branch skipped its slot instruction.");
    a_endian_fixed: assert property (!$past(reset) |-> $stable(endian_reg))
        else $error("Byte order changed outside power-on reset.");
    a_reset_values: assert property (disable iff (1'b0) $past(reset) |-> pc_reg == BOOT_ADDR_P
        && vectorBase_reg == 32'h0 && status_reg[7:4] == 4'hF)
        else $error("Reset values are wrong.");

endmodule

// ---- sim/ccsr_control_state_bench.sv ----
// Self-checking bench for the control-state block; it drives every request group itself.
// Assumes the design package is compiled first, one 50 ns clock and a synchronous reset.
`timescale 1ns/1ns

module ccsr_control_state_bench;
    // ************************************************************
    // Stimulus, outputs and expectation queue
    // ************************************************************
    logic                   clk = 1'h0, reset = 1'h1, por = 1'h1, pin = 1'h1;
    logic                   step = 1'h0, exc = 1'h0, ret = 1'h0;
    logic [31:0]            off = 32'h0, lf = 32'h7E82, pcM = 32'hA0000000, t, vb, g;
    ccsr_pkg::ccsr_branch_s br = '0;
    ccsr_pkg::ccsr_ctrl_s   cr = '0;
    ccsr_pkg::ccsr_flag_s   fr = '0;
    ccsr_pkg::ccsr_mem_s    mr = '0;
    ccsr_pkg::ccsr_lit_s    lr = '0;
    wire  [31:0]            o [13];
    int                     nMismatch = 0, checked = 0, cyc = 0;
    typedef struct { int due; int id; logic [31:0] v; } ccsr_note_s;
    ccsr_note_s             q [$];
    string nm [13] = '{"pc", "status", "saved_status", "saved_ret", "gbase", "vbase",
                       "rdata", "fault", "exc_taken", "addr_err", "load", "literal", "little"};
    logic [1:0]             ms [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic [31:0]            ma [6] = '{32'h3, 32'h0, 32'h2, 32'h1, 32'h2, 32'h4};
    logic [31:0]            md [6] = '{32'h80, 32'h7F, 32'h8001, 32'h7FFF, 32'h1234, 32'h80000001};
    logic [31:0]            ml [6] = '{32'hFFFFFF80, 32'h7F, 32'hFFFF8001, 32'h7FFF, 32'h1234,
                                       32'h80000001};
    logic                   me [6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};

    ccsr_control_state dut (.clk(clk), .reset(reset), .powerOnReset(por), .endianSelectPin(pin),
        .instrStep(step), .branchReq(br), .excReq(exc), .excOffset(off), .returnReq(ret),
        .ctrlReq(cr), .flagReq(fr), .memReq(mr), .litReq(lr), .pc(o[0]), .statusWord(o[1]),
        .savedStatus(o[2]), .savedReturnAddress(o[3]), .globalBase(o[4]), .vectorBase(o[5]),
        .littleEndian(o[12][0]), .ctrlReadData(o[6]), .ctrlFault(o[7][0]),
        .excTaken(o[8][0]), .addrError(o[9][0]), .loadValue(o[10]), .literalValue(o[11]));

    // ************************************************************
    // Helpers and processes
    // ************************************************************
    // Pseudo-random words from a fixed seed, so every run is repeatable.
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    // One-bit outputs sit in bit 0 of their slot; the upper bits are undriven.
    function automatic logic [31:0] val(int i);
        return (i inside {7, 8, 9, 12}) ? {31'h0, o[i][0]} : o[i];
    endfunction
    task automatic note(int id, logic [31:0] v);
        q.push_back('{cyc + 1, id, v});
    endtask
    // The first falling edge is the check point; requests drop there, new ones come later.
    task automatic go();
        @(negedge clk);
        {step, exc, ret, br, cr, fr, mr, lr} = '0;
        @(negedge clk);
    endtask
    task automatic report_and_stop();
        if (q.size() > 0) begin
            nMismatch = nMismatch + 1;
            $display("BAD queue expected 0 seen %0d", q.size());
        end
        if (nMismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Free-running core clock.
    initial forever #25 clk = ~clk;
    // Cycle count and hang guard; the whole sequence needs well under a hundred cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            nMismatch = nMismatch + 1;
            report_and_stop();
        end
    end
    // Results are compared at the falling edge, when rising-edge updates have landed.
    always @(negedge clk) begin
        while (q.size() > 0 && q[0].due == cyc) begin
            checked = checked + 1;
            if (val(q[0].id) !== q[0].v) begin
                nMismatch = nMismatch + 1;
                $display("BAD %s expected %h seen %h", nm[q[0].id], q[0].v, val(q[0].id));
            end
            void'(q.pop_front());
        end
    end

    // Main sequence: reset, sequencing, control moves, exception round trip, loads, literals.
    initial begin
        repeat (12) @(negedge clk);
        reset = 1'h0;
        note(0, 32'hA0000000);
        note(1, 32'h700000F0);
        note(5, 32'h0);
        note(12, 32'h1);
        @(negedge clk);
        step = 1'h1;
        pcM = pcM + 32'h2;
        note(0, pcM);
        go();
        t = rnd() & 32'hFFFFFFFE;
        br = {2'h1, 1'h1, t};
        step = 1'h1;
        note(0, pcM + 32'h2);
        go();
        step = 1'h1;
        note(0, t);
        go();
        br = {2'h2, 1'h1, t + 32'h8};
        step = 1'h1;
        pcM = t + 32'h8;
        note(0, pcM);
        go();
        vb = rnd() & 32'hFFFFFF00;
        cr = {1'h1, 1'h1, 3'h2, vb};
        note(5, vb);
        go();
        cr = {1'h1, 1'h0, 3'h2, 32'h0};
        note(6, vb);
        go();
        cr = {1'h1, 1'h1, 3'h0, 32'hFFFFFFFF};
        note(1, 32'h700003F3);
        go();
        cr = {1'h1, 1'h1, 3'h0, 32'h000000F1};
        note(1, 32'h000000F1);
        go();
        cr = {1'h1, 1'h1, 3'h2, 32'h0};
        note(7, 32'h1);
        note(5, vb);
        go();
        cr = {1'h1, 1'h0, 3'h0, 32'h0};
        note(7, 32'h1);
        go();
        g = rnd();
        cr = {1'h1, 1'h1, 3'h1, g};
        note(4, g);
        note(7, 32'h0);
        go();
        cr = {1'h1, 1'h1, 3'h0, 32'hFFFFFFFF};
        note(1, 32'h000003F3);
        go();
        fr = {1'h1, 3'h1, 1'h0};
        note(1, 32'h000003F2);
        go();
        fr = {1'h1, 3'h0, 1'h1};
        note(1, 32'h000003F2);
        go();
        off = 32'h100;
        exc = 1'h1;
        note(0, vb + 32'h100);
        note(3, pcM);
        note(2, 32'h000003F2);
        note(1, 32'h700003F2);
        note(8, 32'h1);
        go();
        exc = 1'h1;
        note(0, vb + 32'h100);
        note(8, 32'h0);
        go();
        cr = {1'h1, 1'h0, 3'h3, 32'h0};
        note(6, 32'h000003F2);
        go();
        pcM = pcM + 32'h4;
        cr = {1'h1, 1'h1, 3'h4, pcM};
        note(3, pcM);
        go();
        ret = 1'h1;
        note(0, pcM);
        note(1, 32'h000003F2);
        go();
        for (int i = 0; i < 6; i++) begin
            mr = {1'h1, ms[i], ma[i], md[i]};
            note(10, ml[i]);
            note(9, {31'h0, me[i]});
            go();
        end
        for (int i = 0; i < 7; i++) begin
            t = rnd() | 32'h80;
            lr = {1'h1, i[2:0], t[7:0]};
            note(11, (i < 3) ? {24'hFFFFFF, t[7:0]} : {24'h0, t[7:0]});
            go();
        end
        por = 1'h0;
        pin = 1'h0;
        reset = 1'h1;
        note(0, 32'hA0000000);
        note(1, 32'h700000F0);
        note(5, 32'h0);
        note(12, 32'h1);
        go();
        reset = 1'h0;
        @(negedge clk);
        report_and_stop();
    end
endmodule
